// ==== charger_status_pkg.sv ====
package charger_status_pkg;

    localparam int unsigned ADDR_WIDTH = 8;
    localparam int unsigned DATA_WIDTH = 8;

    // Register offsets on the serial control interface
    localparam logic [7:0] CHARGE_AND_SOURCE_STATE_ADDR  = 8'h1E;
    localparam logic [7:0] FAULT_CONDITION_STATE_ADDR    = 8'h1F;
    localparam logic [7:0] REGULATION_EVENT_LATCHES_ADDR = 8'h20;
    localparam logic [7:0] STATE_CHANGE_LATCHES_ADDR     = 8'h21;

    // Reset value shared by all four registers
    localparam logic [7:0] REG_RESET = 8'h00;

    // Charge and source state fields
    localparam int unsigned CHARGE_PHASE_LSB  = 3;
    localparam int unsigned CHARGE_PHASE_MSB  = 4;
    localparam int unsigned INPUT_SOURCE_LSB  = 0;
    localparam int unsigned INPUT_SOURCE_MSB  = 2;
    localparam logic [2:0]  SOURCE_UNKNOWN    = 3'h4;

    // Fault condition state fields
    localparam int unsigned INPUT_FAULT_BIT   = 7;
    localparam int unsigned BATTERY_FAULT_BIT = 6;
    localparam int unsigned SYSTEM_FAULT_BIT  = 5;
    localparam int unsigned DIE_OVERHEAT_BIT  = 3;
    localparam int unsigned THERM_ZONE_LSB    = 0;
    localparam int unsigned THERM_ZONE_MSB    = 2;

    // Regulation event latch positions
    localparam int unsigned CONVERSION_DONE_BIT = 6;
    localparam int unsigned THERMAL_LOOP_BIT    = 5;
    localparam int unsigned MIN_SYS_RAIL_BIT    = 4;
    localparam int unsigned INPUT_CURRENT_BIT   = 3;
    localparam int unsigned INPUT_VOLTAGE_BIT   = 2;
    localparam int unsigned CHARGE_TIMER_BIT    = 1;
    localparam int unsigned HOST_WATCHDOG_BIT   = 0;

    // State change latch positions
    localparam int unsigned PHASE_CHANGE_BIT  = 3;
    localparam int unsigned SOURCE_CHANGE_BIT = 0;

    // Bits that exist; all others read as zero
    localparam logic [7:0] CHARGE_SOURCE_USED = 8'h1F;
    localparam logic [7:0] FAULT_USED         = 8'hEF;
    localparam logic [7:0] REGULATION_USED    = 8'h7F;
    localparam logic [7:0] CHANGE_USED        = 8'h09;

    // Number of level conditions watched by the shared edge detector
    localparam int unsigned EDGE_COUNT = 7;

    typedef enum logic [1:0] {
        PHASE_IDLE     = 2'b00,
        PHASE_CURRENT  = 2'b01,
        PHASE_VOLTAGE  = 2'b10,
        PHASE_TOP_OFF  = 2'b11
    } charge_phase_t;

    typedef enum logic [2:0] {
        ZONE_NORMAL    = 3'b000,
        ZONE_COLD      = 3'b001,
        ZONE_HOT       = 3'b010,
        ZONE_COOL      = 3'b011,
        ZONE_WARM      = 3'b100,
        ZONE_PRE_COOL  = 3'b101,
        ZONE_PRE_WARM  = 3'b110,
        ZONE_BIAS_FAIL = 3'b111
    } thermistor_zone_t;

endpackage

// ==== level_edge_detect.sv ====
`timescale 1ns/1ps
module level_edge_detect #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             i_clock,
    input  wire logic             i_arst_n,
    input  wire logic [WIDTH-1:0] i_level,
    output logic      [WIDTH-1:0] o_rise,
    output logic      [WIDTH-1:0] o_fall
);

    logic [WIDTH-1:0] last_level;
    logic [WIDTH-1:0] next_last_level;

    // Remember last cycle's levels; conditions come from core-clock logic
    always_comb begin
        next_last_level = i_level;
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            last_level <= '0;
        end else begin
            last_level <= next_last_level;
        end
    end

    // A level already high at reset release counts as a rise
    assign o_rise = i_level & ~last_level;
    assign o_fall = ~i_level & last_level;

endmodule

// ==== charger_status_flag_bank.sv ====
// Operation
// - Phase code: idle, current, voltage, top-off
// - Unrecognised adapter reports source code 100b
// - Bit 7 high on input overvoltage or sleep
// - Bit 6 high on battery overcurrent/overvoltage
// - Bit 5 high on rail short/overvoltage
// - Bit 3 high during die thermal shutdown
// - Zone code encodes seven thermistor zones
// - Rail absent gives 1, bias fault 7
// - Conversion flag only in one-shot mode
// - Thermal loop flag on rising edge
// - Min rail flag on entry and exit
// - Current limit flag on either loop rising
// - Input voltage flag on loop rising edge
// - Timer flag on safety timer expiry edge
// - Watchdog flag on watchdog expiry edge
// - Phase change flag when phase code changes
// - Source change flag when source code changes
// - Registers reset zero, reserved zero, read-only
// - Mask bit suppresses notification for flag
`timescale 1ns/1ps
module charger_status_flag_bank (
    input  wire logic                                   i_clock,
    input  wire logic                                   i_arst_n,
    // Register read port from the serial interface slave
    input  wire logic                                   i_read_strobe,
    input  wire logic [charger_status_pkg::ADDR_WIDTH-1:0] i_read_addr,
    output logic      [charger_status_pkg::DATA_WIDTH-1:0] o_read_data,
    output logic                                        o_read_valid,
    // Charge phase conditions
    input  wire logic                                   i_charge_current_phase,
    input  wire logic                                   i_charge_voltage_phase,
    input  wire logic                                   i_top_off_active,
    // Input source
    input  wire logic [2:0]                             i_adapter_code,
    input  wire logic                                   i_adapter_unknown,
    // Fault conditions
    input  wire logic                                   i_input_overvoltage,
    input  wire logic                                   i_input_sleep,
    input  wire logic                                   i_battery_overcurrent,
    input  wire logic                                   i_battery_overvoltage,
    input  wire logic                                   i_system_rail_short,
    input  wire logic                                   i_system_rail_overvoltage,
    input  wire logic                                   i_die_overheat,
    // Thermistor
    input  wire logic [2:0]                             i_thermistor_zone,
    input  wire logic                                   i_thermistor_rail_absent,
    input  wire logic                                   i_thermistor_bias_fault,
    // Regulation and timer conditions
    input  wire logic                                   i_conversion_done,
    input  wire logic                                   i_one_shot_mode,
    input  wire logic                                   i_die_thermal_regulation,
    input  wire logic                                   i_min_system_regulation,
    input  wire logic                                   i_input_current_regulation,
    input  wire logic                                   i_pin_set_current_limit,
    input  wire logic                                   i_input_voltage_regulation,
    input  wire logic                                   i_charge_timer_expired,
    input  wire logic                                   i_host_watchdog_expired,
    // Mask bits held by the mask registers
    input  wire logic [charger_status_pkg::DATA_WIDTH-1:0] i_regulation_mask,
    input  wire logic [charger_status_pkg::DATA_WIDTH-1:0] i_change_mask,
    // Notification pulse towards the interrupt pin driver
    output logic                                        o_notify
);

    import charger_status_pkg::*;

    // Register state
    // Live status copies plus the two event latch bytes
    logic [DATA_WIDTH-1:0] charge_and_source_state;
    logic [DATA_WIDTH-1:0] fault_condition_state;
    logic [DATA_WIDTH-1:0] regulation_event_latches;
    logic [DATA_WIDTH-1:0] state_change_latches;
    logic [DATA_WIDTH-1:0] next_charge_and_source_state;
    logic [DATA_WIDTH-1:0] next_fault_condition_state;
    logic [DATA_WIDTH-1:0] next_regulation_event_latches;
    logic [DATA_WIDTH-1:0] next_state_change_latches;

    // Read port state
    // Read data holds its last value until the next read
    logic [DATA_WIDTH-1:0] read_data;
    logic                  read_valid;
    logic                  notify;
    logic [DATA_WIDTH-1:0] next_read_data;
    logic                  next_read_valid;
    logic                  next_notify;

    // Combinational helpers
    charge_phase_t         charge_phase_code;
    thermistor_zone_t      thermistor_zone_code;
    logic [2:0]            input_source_code;
    logic [DATA_WIDTH-1:0] regulation_set;
    logic [DATA_WIDTH-1:0] change_set;
    logic [DATA_WIDTH-1:0] regulation_clear;
    logic [DATA_WIDTH-1:0] change_clear;
    logic [EDGE_COUNT-1:0] watched_levels;
    logic [EDGE_COUNT-1:0] level_rise;
    logic [EDGE_COUNT-1:0] level_fall;

    // Address decode used by both the data mux and the clear logic
    function automatic logic addr_hit(
        input logic [ADDR_WIDTH-1:0] addr,
        input logic [ADDR_WIDTH-1:0] target
    );
        addr_hit = (addr == target);
    endfunction

    // Edge index assignment for watched levels
    // The watchdog stays out of this vector, on its own detector
    localparam int unsigned EDGE_CONVERSION = 0;
    localparam int unsigned EDGE_THERMAL    = 1;
    localparam int unsigned EDGE_MIN_RAIL   = 2;
    localparam int unsigned EDGE_CURRENT    = 3;
    localparam int unsigned EDGE_PIN_LIMIT  = 4;
    localparam int unsigned EDGE_VOLTAGE    = 5;
    localparam int unsigned EDGE_TIMER      = 6;

    // Conversion done is gated by one-shot mode before edge detection
    always_comb begin
        watched_levels                  = '0;
        watched_levels[EDGE_CONVERSION] = i_conversion_done & i_one_shot_mode;
        watched_levels[EDGE_THERMAL]    = i_die_thermal_regulation;
        watched_levels[EDGE_MIN_RAIL]   = i_min_system_regulation;
        watched_levels[EDGE_CURRENT]    = i_input_current_regulation;
        watched_levels[EDGE_PIN_LIMIT]  = i_pin_set_current_limit;
        watched_levels[EDGE_VOLTAGE]    = i_input_voltage_regulation;
        watched_levels[EDGE_TIMER]      = i_charge_timer_expired;
    end

    // One shared detector; a level that stays high sets its flag only once
    level_edge_detect #(
        .WIDTH (EDGE_COUNT)
    ) u_level_edges (
        .i_clock  (i_clock),
        .i_arst_n (i_arst_n),
        .i_level  (watched_levels),
        .o_rise   (level_rise),
        .o_fall   (level_fall)
    );

    // Watchdog has its own small edge detector to keep the vector compact
    logic watchdog_rise;
    level_edge_detect #(
        .WIDTH (1)
    ) u_watchdog_edge (
        .i_clock  (i_clock),
        .i_arst_n (i_arst_n),
        .i_level  (i_host_watchdog_expired),
        .o_rise   (watchdog_rise),
        .o_fall   ()
    );

    // Charge phase: top-off outranks voltage, voltage outranks current
    // so overlapping phase inputs at a handover still give one code
    always_comb begin
        if (i_top_off_active) begin
            charge_phase_code = PHASE_TOP_OFF;
        end else if (i_charge_voltage_phase) begin
            charge_phase_code = PHASE_VOLTAGE;
        end else if (i_charge_current_phase) begin
            charge_phase_code = PHASE_CURRENT;
        end else begin
            charge_phase_code = PHASE_IDLE;
        end
    end

    // Unrecognised adapter overrides whatever type code detection gives
    always_comb begin
        if (i_adapter_unknown) begin
            input_source_code = SOURCE_UNKNOWN;
        end else begin
            input_source_code = i_adapter_code;
        end
    end

    // Bias fault wins over missing rail; either wins over the measured zone
    // Limitation: a missing rail reads the same as a true cold zone
    always_comb begin
        if (i_thermistor_bias_fault) begin
            thermistor_zone_code = ZONE_BIAS_FAIL;
        end else if (i_thermistor_rail_absent) begin
            thermistor_zone_code = ZONE_COLD;
        end else begin
            thermistor_zone_code = thermistor_zone_t'(i_thermistor_zone);
        end
    end

    // Live status registers follow their conditions every cycle
    always_comb begin
        next_charge_and_source_state = REG_RESET;
        next_charge_and_source_state[CHARGE_PHASE_MSB:CHARGE_PHASE_LSB] = charge_phase_code;
        next_charge_and_source_state[INPUT_SOURCE_MSB:INPUT_SOURCE_LSB] = input_source_code;
        next_fault_condition_state = REG_RESET;
        next_fault_condition_state[INPUT_FAULT_BIT] =
            i_input_overvoltage | i_input_sleep;
        next_fault_condition_state[BATTERY_FAULT_BIT] =
            i_battery_overcurrent | i_battery_overvoltage;
        next_fault_condition_state[SYSTEM_FAULT_BIT] =
            i_system_rail_short | i_system_rail_overvoltage;
        next_fault_condition_state[DIE_OVERHEAT_BIT] = i_die_overheat;
        next_fault_condition_state[THERM_ZONE_MSB:THERM_ZONE_LSB] = thermistor_zone_code;
    end

    // Event sources for the regulation latches
    always_comb begin
        regulation_set = '0;
        regulation_set[CONVERSION_DONE_BIT] = level_rise[EDGE_CONVERSION];
        regulation_set[THERMAL_LOOP_BIT]    = level_rise[EDGE_THERMAL];
        regulation_set[MIN_SYS_RAIL_BIT]    =
            level_rise[EDGE_MIN_RAIL] | level_fall[EDGE_MIN_RAIL];
        regulation_set[INPUT_CURRENT_BIT]   =
            level_rise[EDGE_CURRENT] | level_rise[EDGE_PIN_LIMIT];
        regulation_set[INPUT_VOLTAGE_BIT]   = level_rise[EDGE_VOLTAGE];
        regulation_set[CHARGE_TIMER_BIT]    = level_rise[EDGE_TIMER];
        regulation_set[HOST_WATCHDOG_BIT]   = watchdog_rise;
    end

    // Change events compare the new codes against the reported ones
    // so a code that holds steady never flags a second time
    always_comb begin
        change_set = '0;
        change_set[PHASE_CHANGE_BIT] =
            (next_charge_and_source_state[CHARGE_PHASE_MSB:CHARGE_PHASE_LSB] !=
             charge_and_source_state[CHARGE_PHASE_MSB:CHARGE_PHASE_LSB]);
        change_set[SOURCE_CHANGE_BIT] =
            (next_charge_and_source_state[INPUT_SOURCE_MSB:INPUT_SOURCE_LSB] !=
             charge_and_source_state[INPUT_SOURCE_MSB:INPUT_SOURCE_LSB]);
    end

    // A read clears the whole latch register it targets
    // Safe because the host always sees every bit of the byte it reads
    always_comb begin
        regulation_clear = '0;
        change_clear     = '0;
        if (i_read_strobe && addr_hit(i_read_addr, REGULATION_EVENT_LATCHES_ADDR)) begin
            regulation_clear = '1;
        end
        if (i_read_strobe && addr_hit(i_read_addr, STATE_CHANGE_LATCHES_ADDR)) begin
            change_clear = '1;
        end
    end

    // Set beats clear so an event landing on the read is reported next time
    always_comb begin
        next_regulation_event_latches =
            ((regulation_event_latches & ~regulation_clear) | regulation_set)
            & REGULATION_USED;
        next_state_change_latches =
            ((state_change_latches & ~change_clear) | change_set) & CHANGE_USED;
    end

    // Read mux returns the value before any clear; reserved bits forced low
    always_comb begin
        next_read_valid = i_read_strobe;
        next_read_data  = read_data;
        if (i_read_strobe) begin
            if (addr_hit(i_read_addr, CHARGE_AND_SOURCE_STATE_ADDR)) begin
                next_read_data = charge_and_source_state & CHARGE_SOURCE_USED;
            end else if (addr_hit(i_read_addr, FAULT_CONDITION_STATE_ADDR)) begin
                next_read_data = fault_condition_state & FAULT_USED;
            end else if (addr_hit(i_read_addr, REGULATION_EVENT_LATCHES_ADDR)) begin
                next_read_data = regulation_event_latches & REGULATION_USED;
            end else if (addr_hit(i_read_addr, STATE_CHANGE_LATCHES_ADDR)) begin
                next_read_data = state_change_latches & CHANGE_USED;
            end else begin
                next_read_data = REG_RESET; // Unmapped addresses read zero
            end
        end
    end

    // Pulse only for new, unmasked events; masking never stops the latch
    // Limitation: events on back-to-back cycles merge into one longer pulse
    always_comb begin
        next_notify = |(regulation_set & ~i_regulation_mask & REGULATION_USED) |
                      |(change_set & ~i_change_mask & CHANGE_USED);
    end

    // All state resets to zero; nothing here is host-writable
    // Besides a read, reset is the only way a latch returns to zero
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            charge_and_source_state  <= REG_RESET;
            fault_condition_state    <= REG_RESET;
            regulation_event_latches <= REG_RESET;
            state_change_latches     <= REG_RESET;
            read_data                <= REG_RESET;
            read_valid               <= 1'b0;
            notify                   <= 1'b0;
        end else begin
            charge_and_source_state  <= next_charge_and_source_state;
            fault_condition_state    <= next_fault_condition_state;
            regulation_event_latches <= next_regulation_event_latches;
            state_change_latches     <= next_state_change_latches;
            read_data                <= next_read_data;
            read_valid               <= next_read_valid;
            notify                   <= next_notify;
        end
    end

    // Outputs straight from flip-flops
    assign o_read_data  = read_data;
    assign o_read_valid = read_valid;
    assign o_notify     = notify;

endmodule

// ==== charger_status_flag_bank_asserts.sv ====
`timescale 1ns/1ps
module charger_status_flag_bank_asserts (
    input wire logic       i_clock,
    input wire logic       i_arst_n,
    input wire logic       i_read_strobe,
    input wire logic [7:0] i_read_addr,
    input wire logic       i_top_off_active,
    input wire logic       i_adapter_unknown,
    input wire logic       i_input_overvoltage,
    input wire logic       i_input_sleep,
    input wire logic       i_battery_overcurrent,
    input wire logic       i_battery_overvoltage,
    input wire logic       i_system_rail_short,
    input wire logic       i_system_rail_overvoltage,
    input wire logic       i_die_overheat,
    input wire logic       i_thermistor_bias_fault,
    input wire logic [7:0] o_read_data,
    input wire logic       o_read_valid
);
    import charger_status_pkg::*;
    // Status bytes mirror conditions sampled two edges before the answer
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    sequence s_rd_state;
        i_read_strobe && i_read_addr == CHARGE_AND_SOURCE_STATE_ADDR ##1 o_read_valid;
    endsequence
    sequence s_rd_fault;
        i_read_strobe && i_read_addr == FAULT_CONDITION_STATE_ADDR ##1 o_read_valid;
    endsequence
    property p_valid;
        i_read_strobe |=> o_read_valid;
    endproperty
    a_valid: assert property (p_valid) else $error("read not answered");
    property p_no_valid;
        !i_read_strobe |=> !o_read_valid;
    endproperty
    a_no_valid: assert property (p_no_valid) else $error("answer without read");
    property p_top_off;
        s_rd_state ##0 $past(i_top_off_active, 2) |-> o_read_data[4:3] == 2'h3;
    endproperty
    a_top_off: assert property (p_top_off) else $error("top-off phase code wrong");
    property p_unknown;
        s_rd_state ##0 $past(i_adapter_unknown, 2) |-> o_read_data[2:0] == SOURCE_UNKNOWN;
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown source code wrong");
    property p_state_rsv;
        s_rd_state |-> o_read_data[7:5] == 3'h0;
    endproperty
    a_state_rsv: assert property (p_state_rsv) else $error("reserved bits set");
    property p_input_fault;
        s_rd_fault |-> o_read_data[7] == ($past(i_input_overvoltage, 2) | $past(i_input_sleep, 2));
    endproperty
    a_input_fault: assert property (p_input_fault) else $error("input fault bit wrong");
    property p_batt_fault;
        s_rd_fault |->
            o_read_data[6] == ($past(i_battery_overcurrent, 2) | $past(i_battery_overvoltage, 2));
    endproperty
    a_batt_fault: assert property (p_batt_fault) else $error("battery fault bit wrong");
    property p_rail_fault;
        s_rd_fault |->
            o_read_data[5] == ($past(i_system_rail_short, 2) | $past(i_system_rail_overvoltage, 2));
    endproperty
    a_rail_fault: assert property (p_rail_fault) else $error("rail fault bit wrong");
    property p_overheat;
        s_rd_fault |-> o_read_data[3] == $past(i_die_overheat, 2) && !o_read_data[4];
    endproperty
    a_overheat: assert property (p_overheat) else $error("overheat bit wrong");
    property p_bias;
        s_rd_fault ##0 $past(i_thermistor_bias_fault, 2) |-> o_read_data[2:0] == 3'h7;
    endproperty
    a_bias: assert property (p_bias) else $error("bias fault zone wrong");
endmodule
bind charger_status_flag_bank charger_status_flag_bank_asserts u_asserts (
    .i_clock, .i_arst_n, .i_read_strobe, .i_read_addr, .i_top_off_active, .i_adapter_unknown,
    .i_input_overvoltage, .i_input_sleep, .i_battery_overcurrent, .i_battery_overvoltage,
    .i_system_rail_short, .i_system_rail_overvoltage, .i_die_overheat,
    .i_thermistor_bias_fault, .o_read_data, .o_read_valid);

// ==== host_model.sv ====
`timescale 1ns/1ps
module host_model (
    input  wire logic       i_clock,
    output logic            o_read_strobe,
    output logic [7:0]      o_read_addr,
    input  wire logic [7:0] i_read_data,
    input  wire logic       i_read_valid
);
    // Idle address is the inverse of the last one, so stale values never match
    initial begin
        o_read_strobe = 1'b0;
        o_read_addr   = 8'hFF;
    end
    // One-cycle strobe; answer taken once it has settled after the strobe edge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge i_clock);
        o_read_strobe <= 1'b1;
        o_read_addr   <= a;
        @(posedge i_clock);
        o_read_strobe <= 1'b0;
        o_read_addr   <= ~a;
        #1;
        d  = i_read_data;
        ok = i_read_valid;
    endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import charger_status_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        strobe;
    logic [7:0]  addr;
    logic [7:0]  data;
    logic        valid;
    logic        notify;
    logic [21:0] lv;
    logic [2:0]  src;
    logic [2:0]  zone;
    logic [7:0]  rmask;
    logic [7:0]  cmask;
    int          n_mismatch;
    int          n_checks;
    int          n_notify = 0;
    int          base;
    logic [2:0]  ph_in [4] = '{3'b000, 3'b001, 3'b011, 3'b111};
    int          fbit [7] = '{7, 7, 6, 6, 5, 5, 3};
    int          eidx [8] = '{13, 15, 16, 17, 18, 19, 20, 21};
    int          ebit [8] = '{6, 5, 4, 3, 3, 2, 1, 0};

    host_model u_host_model (.i_clock(clk), .o_read_strobe(strobe), .o_read_addr(addr),
        .i_read_data(data), .i_read_valid(valid));
    // Every one-bit condition comes from one vector so tables can index it; adapter code and zone come from src and zone
    charger_status_flag_bank u_charger_status_flag_bank (.i_clock(clk), .i_arst_n(rst_n),
        .i_read_strobe(strobe), .i_read_addr(addr), .o_read_data(data), .o_read_valid(valid),
        .i_charge_current_phase(lv[0]), .i_charge_voltage_phase(lv[1]),
        .i_top_off_active(lv[2]), .i_adapter_code(src), .i_adapter_unknown(lv[3]),
        .i_input_overvoltage(lv[4]), .i_input_sleep(lv[5]), .i_battery_overcurrent(lv[6]),
        .i_battery_overvoltage(lv[7]), .i_system_rail_short(lv[8]),
        .i_system_rail_overvoltage(lv[9]), .i_die_overheat(lv[10]), .i_thermistor_zone(zone),
        .i_thermistor_rail_absent(lv[11]), .i_thermistor_bias_fault(lv[12]),
        .i_conversion_done(lv[13]), .i_one_shot_mode(lv[14]),
        .i_die_thermal_regulation(lv[15]), .i_min_system_regulation(lv[16]),
        .i_input_current_regulation(lv[17]), .i_pin_set_current_limit(lv[18]),
        .i_input_voltage_regulation(lv[19]), .i_charge_timer_expired(lv[20]),
        .i_host_watchdog_expired(lv[21]), .i_regulation_mask(rmask), .i_change_mask(cmask),
        .o_notify(notify));

    always #50 clk = ~clk;
    // Pulse counter; masking is judged by the difference across a window
    always @(posedge clk) if (notify === 1'b1) n_notify += 1;

    task check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        u_host_model.read_reg(a, d, ok);
        check("read valid", 8'h01, {7'h0, ok});
        check($sformatf("reg %h", a), exp, d);
    endtask
    // Condition changes land just after an edge, then settle two more edges
    task setl(input int i, input logic v);
        @(posedge clk);
        lv[i] <= v;
        repeat (2) @(posedge clk);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        lv = '0;
        src = 3'h0;
        zone = 3'h0;
        rmask = 8'h00;
        cmask = 8'h00;
        n_mismatch = 0;
        n_checks = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 8'h1E; a <= 8'h22; a++) rd(8'(a), REG_RESET);
        $display("test reset done");
        // Higher phases override lower ones; each change latches once
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            lv[2:0] <= ph_in[i];
            repeat (2) @(posedge clk);
            rd(CHARGE_AND_SOURCE_STATE_ADDR, {3'h0, 2'(i), 3'h0});
            rd(STATE_CHANGE_LATCHES_ADDR, (i > 0) ? 8'h08 : 8'h00);
        end
        @(posedge clk);
        src <= 3'h2;
        repeat (2) @(posedge clk);
        rd(CHARGE_AND_SOURCE_STATE_ADDR, 8'h1A);
        rd(STATE_CHANGE_LATCHES_ADDR, 8'h01);
        setl(3, 1'b1);
        rd(CHARGE_AND_SOURCE_STATE_ADDR, 8'h1C);
        rd(STATE_CHANGE_LATCHES_ADDR, 8'h01);
        rd(STATE_CHANGE_LATCHES_ADDR, 8'h00);
        $display("test phase and source done");
        for (int i = 0; i < 7; i++) begin
            setl(4 + i, 1'b1);
            rd(FAULT_CONDITION_STATE_ADDR, 8'h01 << fbit[i]);
            setl(4 + i, 1'b0);
        end
        for (int z = 0; z < 7; z++) begin
            @(posedge clk);
            zone <= 3'(z);
            repeat (2) @(posedge clk);
            rd(FAULT_CONDITION_STATE_ADDR, 8'(z));
        end
        setl(11, 1'b1);
        rd(FAULT_CONDITION_STATE_ADDR, 8'h01);
        setl(12, 1'b1);
        rd(FAULT_CONDITION_STATE_ADDR, 8'h07);
        setl(11, 1'b0);
        setl(12, 1'b0);
        $display("test faults done");
        // Conversion done outside one-shot mode must not latch
        setl(13, 1'b1);
        rd(REGULATION_EVENT_LATCHES_ADDR, 8'h00);
        setl(13, 1'b0);
        setl(14, 1'b1);
        for (int i = 0; i < 8; i++) begin
            setl(eidx[i], 1'b1);
            rd(REGULATION_EVENT_LATCHES_ADDR, 8'h01 << ebit[i]);
            rd(REGULATION_EVENT_LATCHES_ADDR, 8'h00);
            setl(eidx[i], 1'b0);
            rd(REGULATION_EVENT_LATCHES_ADDR, (eidx[i] == 16) ? 8'h10 : 8'h00);
        end
        $display("test flags done");
        // A masked event still latches but stays silent
        @(posedge clk);
        cmask <= 8'h08;
        base = n_notify;
        setl(2, 1'b0);
        repeat (2) @(posedge clk);
        check("masked change notify", 8'h00, 8'(n_notify - base));
        rd(STATE_CHANGE_LATCHES_ADDR, 8'h08);
        @(posedge clk);
        rmask <= 8'h20;
        base = n_notify;
        setl(15, 1'b1);
        repeat (2) @(posedge clk);
        check("masked notify", 8'h00, 8'(n_notify - base));
        rd(REGULATION_EVENT_LATCHES_ADDR, 8'h20);
        setl(15, 1'b0);
        base = n_notify;
        setl(21, 1'b1);
        repeat (2) @(posedge clk);
        check("notify", 8'h01, 8'(n_notify - base));
        $display("test notify done");
        finish_test();
    end
endmodule
